// File: pkg/teletext_request_strobe_pkg.sv
// Package for the teletext request timing block: map, resets, fields, states
package teletext_request_strobe_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_HSTART  = 8'h73;
  localparam logic [7:0] IDX_DELAY   = 8'h74;
  localparam logic [7:0] IDX_OVS     = 8'h76;
  localparam logic [7:0] IDX_OVE     = 8'h77;
  localparam logic [7:0] IDX_EVS     = 8'h78;
  localparam logic [7:0] IDX_EVE     = 8'h79;
  localparam logic [7:0] IDX_FAL     = 8'h7A;
  localparam logic [7:0] IDX_LAL     = 8'h7B;
  localparam logic [7:0] IDX_MODE    = 8'h7C;
  localparam logic [7:0] IDX_CTRL    = 8'h7D;
  localparam logic [7:0] IDX_MASK_LO = 8'h7E;
  localparam logic [7:0] IDX_MASK_HI = 8'h7F;
  localparam logic [7:0] IDX_STATUS  = 8'h80;
  // ----------------------------------------
  // Reset values (PAL / NTSC strap)
  // ----------------------------------------
  localparam logic [7:0] RST_DELAY       = 8'h02;
  localparam logic [7:0] DELAY_MIN       = 8'h02;
  localparam logic [7:0] RST_HSTART_PAL  = 8'h42;
  localparam logic [7:0] RST_HSTART_NTSC = 8'h54;
  localparam logic [7:0] RST_OVS_PAL     = 8'h05;
  localparam logic [7:0] RST_OVS_NTSC    = 8'h06;
  localparam logic [7:0] RST_OVE_PAL     = 8'h16;
  localparam logic [7:0] RST_OVE_NTSC    = 8'h10;
  localparam logic [7:0] RST_EVS_PAL     = 8'h04;
  localparam logic [7:0] RST_EVS_NTSC    = 8'h05;
  localparam logic [7:0] RST_EVE_PAL     = 8'h16;
  localparam logic [7:0] RST_EVE_NTSC    = 8'h10;
  localparam logic [7:0] RST_FAL         = 8'h00;
  localparam logic [7:0] RST_LAL         = 8'h00;
  localparam logic [15:0] RST_MASK       = 16'h0000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_STD_BIT   = 7;
  localparam int MODE_PROTO_BIT = 6;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_FIELD_RATE_60HZ_SELECT_BIT  = 1;
  localparam int CTRL_AUX_BIT   = 2;
  localparam int STAT_ODD_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_ACT_BIT   = 2;
  localparam int STAT_OVF_BIT   = 3;
  // ----------------------------------------
  // Line arithmetic and timing counts
  // ----------------------------------------
  localparam logic [8:0] M_START_OFS = 9'h004;
  localparam logic [8:0] O_START_OFS = 9'h001;
  localparam logic [8:0] M_END_OFS   = 9'h003;
  localparam logic [8:0] O_END_OFS   = 9'h000;
  localparam logic [8:0] MASK_BASE   = 9'h007;
  localparam logic [7:0] BIT_DIV     = 8'h04;
  localparam logic [8:0] BITS_EURO   = 9'h168;
  localparam logic [8:0] BITS_NABTS  = 9'h120;
  localparam logic [8:0] BITS_WST60  = 9'h128;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_BURST = 1'b1
  } teletext_request_strobe_state_type;

  // Setting to line number; first selects start or end offset
  function automatic logic [8:0] teletext_request_strobe_line(input logic [7:0] s, input logic m, input logic first);
    logic [8:0] o;
    o = first ? (m ? M_START_OFS : O_START_OFS) : (m ? M_END_OFS : O_END_OFS);
    return {1'b0, s} + o;
  endfunction : teletext_request_strobe_line

  function automatic logic [8:0] teletext_request_strobe_nbits(input logic std, input logic m);
    return m ? (std ? BITS_WST60 : BITS_NABTS) : BITS_EURO;
  endfunction : teletext_request_strobe_nbits
endpackage : teletext_request_strobe_pkg

// File: src/teletext_request_strobe_top.sv
// Teletext request strobe generator with register slave, capture and FIFO
`timescale 1ns/100ps
`default_nettype none

module teletext_request_strobe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign in_ready  = (cnt_ff != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];

  always_comb
  begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wr  = push ? ((wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? ((rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
    if (push)
      mem_ff[wr_ff] <= in_data;
  end
endmodule : teletext_request_strobe_fifo

module teletext_request_strobe_top import teletext_request_strobe_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter int DLY_LEN    = 256
) (
  // Clock, reset, strap (1 = NTSC)
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        strap_ntsc,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Video timing pulses
  input  wire logic        line_start,
  input  wire logic        odd_field_sync,
  input  wire logic        even_field_sync,
  // Teletext pins
  input  wire logic        aux_clock_in,
  input  wire logic        teletext_data_input_pin,
  output logic             request_or_aux_clock_pin,
  output logic             active_line_flag,
  // Captured byte stream
  output logic             ttx_out_valid,
  output logic [7:0]       ttx_out_data,
  input  wire logic        ttx_out_ready
);
  // ----------------------------------------
  // Register file and bus slave
  // ----------------------------------------
  logic [7:0]  hstart_ff, nxt_hstart, delay_ff, nxt_delay;
  logic [7:0]  ovs_ff, nxt_ovs, ove_ff, nxt_ove, evs_ff, nxt_evs, eve_ff, nxt_eve;
  logic [7:0]  fal_ff, nxt_fal, lal_ff, nxt_lal;
  logic        std_ff, nxt_std, proto_ff, nxt_proto;
  logic        en_ff, nxt_en, field_rate_60hz_select_ff, nxt_field_rate_60hz_select, aux_sel_ff, nxt_aux_sel;
  logic [15:0] mask_ff, nxt_mask;
  logic        ovf_ff, nxt_ovf;
  logic        wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0]  idx, wd, rd_byte, status;
  logic        wr_en, ovf_set;
  logic        odd_ff, act_ff;
  teletext_request_strobe_state_type state_ff;

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  always_comb
  begin
    idx    = avs_address[9:2];
    wd     = avs_writedata[7:0];
    status = '0;
    status[STAT_ODD_BIT]  = odd_ff;
    status[STAT_BUSY_BIT] = (state_ff == ST_BURST);
    status[STAT_ACT_BIT]  = act_ff;
    status[STAT_OVF_BIT]  = ovf_ff;
    case (idx)
      IDX_HSTART:  rd_byte = hstart_ff;
      IDX_DELAY:   rd_byte = delay_ff;
      IDX_OVS:     rd_byte = ovs_ff;
      IDX_OVE:     rd_byte = ove_ff;
      IDX_EVS:     rd_byte = evs_ff;
      IDX_EVE:     rd_byte = eve_ff;
      IDX_FAL:     rd_byte = fal_ff;
      IDX_LAL:     rd_byte = lal_ff;
      IDX_MODE:    rd_byte = {std_ff, proto_ff, 6'h00};
      IDX_CTRL:    rd_byte = {5'h00, aux_sel_ff, field_rate_60hz_select_ff, en_ff};
      IDX_MASK_LO: rd_byte = mask_ff[7:0];
      IDX_MASK_HI: rd_byte = mask_ff[15:8];
      IDX_STATUS:  rd_byte = status;
      default:     rd_byte = 8'h00;
    endcase
    // One wait cycle, then the answer; write lands where wait is seen low
    nxt_wait  = !((avs_read || avs_write) && wait_ff);
    nxt_rdata = (avs_read && wait_ff) ? {24'h000000, rd_byte} : rdata_ff;
    wr_en     = avs_write && !wait_ff && avs_byteenable[0];
    nxt_hstart  = hstart_ff;
    nxt_delay   = delay_ff;
    nxt_ovs     = ovs_ff;
    nxt_ove     = ove_ff;
    nxt_evs     = evs_ff;
    nxt_eve     = eve_ff;
    nxt_fal     = fal_ff;
    nxt_lal     = lal_ff;
    nxt_std     = std_ff;
    nxt_proto   = proto_ff;
    nxt_en      = en_ff;
    nxt_field_rate_60hz_select    = field_rate_60hz_select_ff;
    nxt_aux_sel = aux_sel_ff;
    nxt_mask    = mask_ff;
    nxt_ovf     = ovf_ff;
    if (wr_en)
    begin
      case (idx)
        IDX_HSTART:  nxt_hstart = wd;
        IDX_DELAY:   nxt_delay = (wd < DELAY_MIN) ? DELAY_MIN : wd;
        IDX_OVS:     nxt_ovs = wd;
        IDX_OVE:     nxt_ove = wd;
        IDX_EVS:     nxt_evs = wd;
        IDX_EVE:     nxt_eve = wd;
        IDX_FAL:     nxt_fal = wd;
        IDX_LAL:     nxt_lal = wd;
        IDX_MODE:
        begin
          nxt_std   = wd[MODE_STD_BIT];
          nxt_proto = wd[MODE_PROTO_BIT];
        end
        IDX_CTRL:
        begin
          nxt_en      = wd[CTRL_EN_BIT];
          nxt_field_rate_60hz_select    = wd[CTRL_FIELD_RATE_60HZ_SELECT_BIT];
          nxt_aux_sel = wd[CTRL_AUX_BIT];
        end
        IDX_MASK_LO: nxt_mask[7:0] = wd;
        IDX_MASK_HI: nxt_mask[15:8] = wd;
        IDX_STATUS:  nxt_ovf = ovf_ff && !wd[STAT_OVF_BIT];
        default:     nxt_ovf = ovf_ff;
      endcase
    end
    // A new overflow beats a clear in the same cycle
    if (ovf_set)
      nxt_ovf = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      // Strap is a level sampled inside the clocked reset
      hstart_ff  <= strap_ntsc ? RST_HSTART_NTSC : RST_HSTART_PAL;
      delay_ff   <= RST_DELAY;
      ovs_ff     <= strap_ntsc ? RST_OVS_NTSC : RST_OVS_PAL;
      ove_ff     <= strap_ntsc ? RST_OVE_NTSC : RST_OVE_PAL;
      evs_ff     <= strap_ntsc ? RST_EVS_NTSC : RST_EVS_PAL;
      eve_ff     <= strap_ntsc ? RST_EVE_NTSC : RST_EVE_PAL;
      fal_ff     <= RST_FAL;
      lal_ff     <= RST_LAL;
      std_ff     <= 1'b0;
      proto_ff   <= 1'b0;
      en_ff      <= 1'b0;
      field_rate_60hz_select_ff    <= strap_ntsc;
      aux_sel_ff <= 1'b0;
      mask_ff    <= RST_MASK;
      ovf_ff     <= 1'b0;
      wait_ff    <= 1'b1;
      rdata_ff   <= '0;
    end
    else
    begin
      hstart_ff  <= nxt_hstart;
      delay_ff   <= nxt_delay;
      ovs_ff     <= nxt_ovs;
      ove_ff     <= nxt_ove;
      evs_ff     <= nxt_evs;
      eve_ff     <= nxt_eve;
      fal_ff     <= nxt_fal;
      lal_ff     <= nxt_lal;
      std_ff     <= nxt_std;
      proto_ff   <= nxt_proto;
      en_ff      <= nxt_en;
      field_rate_60hz_select_ff    <= nxt_field_rate_60hz_select;
      aux_sel_ff <= nxt_aux_sel;
      mask_ff    <= nxt_mask;
      ovf_ff     <= nxt_ovf;
      wait_ff    <= nxt_wait;
      rdata_ff   <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Line and field timing
  // ----------------------------------------
  logic [8:0]  line_ff, nxt_line;
  logic [11:0] hcnt_ff, nxt_hcnt;
  logic        nxt_odd, nxt_act, in_odd, in_even, mask_hit, line_ok;
  logic [8:0]  mofs;

  always_comb
  begin
    nxt_line = line_ff;
    nxt_odd  = odd_ff;
    if (odd_field_sync || even_field_sync)
    begin
      nxt_line = '0;
      nxt_odd  = odd_field_sync;
    end
    else if (line_start)
      nxt_line = line_ff + 9'h001;
    nxt_hcnt = line_start ? '0 : ((hcnt_ff == 12'hFFF) ? hcnt_ff : hcnt_ff + 12'h001);
    nxt_act  = (line_ff >= teletext_request_strobe_line(fal_ff, field_rate_60hz_select_ff, 1'b1)) &&
               (line_ff <= teletext_request_strobe_line(lal_ff, field_rate_60hz_select_ff, 1'b0));
    in_odd   = odd_ff && (line_ff >= teletext_request_strobe_line(ovs_ff, field_rate_60hz_select_ff, 1'b1)) &&
               (line_ff <= teletext_request_strobe_line(ove_ff, field_rate_60hz_select_ff, 1'b0));
    in_even  = !odd_ff && (line_ff >= teletext_request_strobe_line(evs_ff, field_rate_60hz_select_ff, 1'b1)) &&
               (line_ff <= teletext_request_strobe_line(eve_ff, field_rate_60hz_select_ff, 1'b0));
    mofs     = line_ff - MASK_BASE;
    mask_hit = (line_ff >= MASK_BASE) && (mofs < 9'h010) && mask_ff[mofs[3:0]];
    line_ok  = en_ff && (in_odd || in_even) && !mask_hit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      line_ff <= '0;
      hcnt_ff <= '0;
      odd_ff  <= 1'b1;
      act_ff  <= 1'b0;
    end
    else
    begin
      line_ff <= nxt_line;
      hcnt_ff <= nxt_hcnt;
      odd_ff  <= nxt_odd;
      act_ff  <= nxt_act;
    end
  end

  // ----------------------------------------
  // Request strobe generator
  // ----------------------------------------
  teletext_request_strobe_state_type nxt_state;
  logic [7:0] div_ff, nxt_div;
  logic [8:0] bits_ff, nxt_bits;
  logic       strobe_ff, nxt_strobe, mark_ff, nxt_mark, pin_ff, nxt_pin, tick;
  logic       fifo_in_ready;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_div   = div_ff;
    nxt_bits  = bits_ff;
    // A full FIFO stalls bit requests, so back-pressure reaches the source only while the per-bit strobe (proto_ff low) drives the pin
    tick      = (state_ff == ST_BURST) && (div_ff == 8'h00) && fifo_in_ready;
    case (state_ff)
      ST_IDLE:
      begin
        if (line_ok && (hcnt_ff == {4'h0, hstart_ff}) && fifo_in_ready)
        begin
          nxt_state = ST_BURST;
          nxt_div   = 8'h00;
          nxt_bits  = 9'h000;
        end
      end
      ST_BURST:
      begin
        if (div_ff != 8'h00 || fifo_in_ready)
          nxt_div = (div_ff == BIT_DIV - 8'h01) ? 8'h00 : div_ff + 8'h01;
        if (tick)
          nxt_bits = bits_ff + 9'h001;
        if (line_start || (tick && nxt_bits == teletext_request_strobe_nbits(std_ff, field_rate_60hz_select_ff)))
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_mark   = tick;
    nxt_strobe = proto_ff ? (nxt_state == ST_BURST) : tick;
    nxt_pin    = aux_sel_ff ? aux_clock_in : nxt_strobe;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_ff  <= ST_IDLE;
      div_ff    <= '0;
      bits_ff   <= '0;
      strobe_ff <= 1'b0;
      mark_ff   <= 1'b0;
      pin_ff    <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      div_ff    <= nxt_div;
      bits_ff   <= nxt_bits;
      strobe_ff <= nxt_strobe;
      mark_ff   <= nxt_mark;
      pin_ff    <= nxt_pin;
    end
  end
  assign request_or_aux_clock_pin = pin_ff;
  assign active_line_flag         = act_ff;

  // ----------------------------------------
  // Delayed capture, byte packing, FIFO
  // ----------------------------------------
  logic [DLY_LEN-1:0] sr_ff, nxt_sr;
  logic [7:0] shift_ff, nxt_shift, word_ff, nxt_word;
  logic [2:0] nbit_ff, nxt_nbit;
  logic       wvalid_ff, nxt_wvalid, capture, f_valid, pop;
  logic [7:0] f_data;
  logic       ov_ff, nxt_ov;
  logic [7:0] od_ff, nxt_od;

  always_comb
  begin
    nxt_sr     = {sr_ff[DLY_LEN-2:0], mark_ff};
    capture    = sr_ff[delay_ff - 8'h02];
    nxt_shift  = capture ? {teletext_data_input_pin, shift_ff[7:1]} : shift_ff;
    nxt_nbit   = capture ? nbit_ff + 3'h1 : nbit_ff;
    nxt_wvalid = capture && (nbit_ff == 3'h7);
    nxt_word   = nxt_wvalid ? nxt_shift : word_ff;
    ovf_set    = wvalid_ff && !fifo_in_ready;
    pop        = f_valid && (!ov_ff || ttx_out_ready);
    nxt_ov     = pop || (ov_ff && !ttx_out_ready);
    nxt_od     = pop ? f_data : od_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sr_ff     <= '0;
      shift_ff  <= '0;
      nbit_ff   <= '0;
      wvalid_ff <= 1'b0;
      word_ff   <= '0;
      ov_ff     <= 1'b0;
      od_ff     <= '0;
    end
    else
    begin
      sr_ff     <= nxt_sr;
      shift_ff  <= nxt_shift;
      nbit_ff   <= nxt_nbit;
      wvalid_ff <= nxt_wvalid;
      word_ff   <= nxt_word;
      ov_ff     <= nxt_ov;
      od_ff     <= nxt_od;
    end
  end
  assign ttx_out_valid = ov_ff;
  assign ttx_out_data  = od_ff;

  teletext_request_strobe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (wvalid_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (word_ff),
    .out_valid (f_valid),
    .out_ready (!ov_ff || ttx_out_ready),
    .out_data  (f_data)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_burst_start;
    (state_ff == ST_IDLE) ##1 (state_ff == ST_BURST);
  endsequence

  AST_DELAY_FLOOR: assert property (delay_ff >= DELAY_MIN)
    else $error("delay below minimum");
  AST_CAPTURE_AT_DELAY: assert property (mark_ff && delay_ff == 8'h02 |=> capture)
    else $error("capture not at programmed delay");
  AST_START_IN_WINDOW: assert property (s_burst_start |-> $past(line_ok))
    else $error("burst started on a forbidden line");
  AST_MASKED_LINE: assert property (state_ff == ST_IDLE && mask_hit |=> state_ff == ST_IDLE)
    else $error("burst started on a masked line");
  AST_PROTO0_PULSE: assert property (!proto_ff && strobe_ff |=> !strobe_ff)
    else $error("per-bit strobe wider than one cycle");
  AST_PROTO1_WINDOW: assert property ($past(proto_ff) |-> strobe_ff == (state_ff == ST_BURST))
    else $error("window strobe does not follow burst");
  AST_PIN_SELECT: assert property ($past(!aux_sel_ff) |-> pin_ff == strobe_ff)
    else $error("strobe missing on shared pin");
  AST_OFF_AFTER_RESET: assert property ($past(srst) |-> !en_ff && !std_ff && delay_ff == RST_DELAY)
    else $error("reset defaults wrong");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not after one wait cycle");
endmodule : teletext_request_strobe_top

`default_nettype wire

// File: tb/teletext_request_strobe_source_model.sv
// Behavioural teletext bit source answering each rising edge of the request strobe
`timescale 1ns/100ps
`default_nettype none
module teletext_request_strobe_source_model #(
  parameter int DLY = 2
) (
  // Clock and strobe from the block
  input  wire logic sys_clk,
  input  wire logic strobe,
  // Serial data back to the block
  output logic      data_out
);
  logic       prev_q;
  logic [7:0] hist_q;
  logic [8:0] rise_v;
  logic [7:0] byte_q;
  logic [2:0] bpos_q;
  initial {prev_q, hist_q, byte_q, bpos_q, data_out} = '0;
  assign rise_v = {hist_q, strobe & ~prev_q};
  // Bit 8k+j of the stream is bit j of k, so captured bytes simply count up
  always @(posedge sys_clk)
  begin
    prev_q <= strobe;
    hist_q <= rise_v[7:0];
    if (rise_v[DLY-2])
    begin
      data_out <= byte_q[bpos_q];
      bpos_q   <= bpos_q + 3'h1;
      if (bpos_q == 3'h7)
        byte_q <= byte_q + 8'h01;
    end
    else
      data_out <= ~data_out; // Hold time over: line no longer shows the bit
  end
endmodule : teletext_request_strobe_source_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the teletext request timing block
`timescale 1ns/100ps
`default_nettype none
module testbench import teletext_request_strobe_pkg::*;;
  localparam int LINE_LEN = 1600;
  logic        sys_clk = 1'b0, srst = 1'b1, strap_ntsc = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [9:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, line_start = 1'b0, odd_sync = 1'b0, even_sync = 1'b0, aux_in = 1'b0, aux_q;
  logic        ttx_data, pin, act_flag, out_valid, out_ready = 1'b1, chk_on = 1'b1;
  logic [7:0]  out_data, exp_byte = 8'h00;
  int          fails = 0, cmp_count = 0;
  localparam logic [7:0] RIDX [11] = '{IDX_HSTART, IDX_DELAY, IDX_OVS, IDX_OVE, IDX_EVS, IDX_EVE, IDX_FAL,
                                       IDX_LAL, IDX_MODE, IDX_MASK_LO, 8'h90};
  localparam logic [7:0] RVAL [11] = '{8'h42, 8'h02, 8'h05, 8'h16, 8'h04, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  initial forever #5 sys_clk = ~sys_clk;

  teletext_request_strobe_top uut (.sys_clk(sys_clk), .srst(srst), .strap_ntsc(strap_ntsc), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_start(line_start),
    .odd_field_sync(odd_sync), .even_field_sync(even_sync), .aux_clock_in(aux_in),
    .teletext_data_input_pin(ttx_data), .request_or_aux_clock_pin(pin), .active_line_flag(act_flag),
    .ttx_out_valid(out_valid), .ttx_out_data(out_data), .ttx_out_ready(out_ready));

  teletext_request_strobe_source_model #(.DLY(2)) source (.sys_clk(sys_clk), .strobe(pin), .data_out(ttx_data));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low at a rising edge; data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wdata, input logic be0);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h0, wdata};
    avs_byteenable <= {3'h7, be0};
    avs_write      <= wr;
    avs_read       <= ~wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    check(n < 100, 1'b1, "bus answer");
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 1'b1);
    check(rd, {24'h0, exp}, "register");
  endtask : rd_chk

  // One field of 9 lines: strobe rises counted per line, active flag sampled mid-line
  task automatic field_run(input logic odd, input int lo, input int hi, input int rises,
                           input int alo, input int ahi, input int skip);
    int   cnt;
    logic last;
    for (int k = 0; k < 9; k++)
    begin
      @(posedge sys_clk);
      if (k == 0)
        {odd_sync, even_sync} <= {odd, ~odd};
      else
        line_start <= 1'b1;
      @(posedge sys_clk);
      {line_start, odd_sync, even_sync} <= 3'b000;
      cnt  = 0;
      last = 1'b0;
      for (int n = 0; n < LINE_LEN; n++)
      begin
        @(negedge sys_clk);
        if (pin === 1'b1 && last === 1'b0)
          cnt++;
        last = pin;
        if (n == LINE_LEN / 2)
          check(act_flag, k >= alo && k <= ahi, "active line");
      end
      if (k != skip)
        check(cnt, (k >= lo && k <= hi) ? rises : 0, "strobe rises");
    end
  endtask : field_run

  // Captured bytes must follow the source stream in order
  always @(posedge sys_clk)
  begin
    if (chk_on && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      check(out_data, exp_byte, "captured byte");
      exp_byte <= exp_byte + 8'h01;
    end
    aux_q <= aux_in;
  end

  task automatic results;
    $display("compares %0d, errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial
  begin
    #990000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 11; i++)
      rd_chk(RIDX[i], RVAL[i]);
    rd_chk(IDX_CTRL, 8'h00);
    wr(IDX_DELAY, 8'h01);
    rd_chk(IDX_DELAY, 8'h02);
    bus(1'b1, IDX_DELAY, 8'h09, 1'b0);
    rd_chk(IDX_DELAY, 8'h02);
    wr(IDX_OVE, 8'h07);
    wr(IDX_FAL, 8'h02);
    wr(IDX_LAL, 8'h04);
    field_run(1'b1, 6, 7, 0, 3, 4, -1);
    wr(IDX_CTRL, 8'h01);
    field_run(1'b1, 6, 7, 360, 3, 4, -1);
    check(exp_byte, 8'h5A, "byte count");
    wr(IDX_MASK_LO, 8'h01);
    out_ready <= 1'b0;
    field_run(1'b1, 6, 6, 360, 3, 4, 6);
    check(out_valid, 1'b1, "buffer full");
    out_ready <= 1'b1;
    repeat (100) @(posedge sys_clk);
    check(out_valid, 1'b0, "buffer drained");
    wr(IDX_MASK_LO, 8'h00);
    wr(IDX_CTRL, 8'h03);
    wr(IDX_EVS, 8'h02);
    wr(IDX_EVE, 8'h04);
    field_run(1'b0, 6, 7, 288, 6, 7, -1);
    wr(IDX_MODE, 8'h80);
    field_run(1'b0, 6, 7, 296, 6, 7, -1);
    chk_on = 1'b0;
    wr(IDX_MODE, 8'hC0);
    field_run(1'b0, 6, 7, 1, 6, 7, -1);
    wr(IDX_CTRL, 8'h04);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      aux_in <= i[0];
      @(negedge sys_clk);
      if (i > 0)
        check(pin, aux_q, "aux pass");
    end
    results();
  end
endmodule : testbench
`default_nettype wire
